// [hdl/sysctl_clock_divider.sv]
// Purpose: Cascaded divide-by-2 and divide-by-256 of the crystal rate
// Assumes: One core clock cycle stands for one crystal period
// Notes:   Output is a one-cycle tick per divided period
`default_nettype none
`timescale 1ns/100ps
`include "sysctl_regs.svh"

module sysctl_clock_divider (
  input  wire logic i_clk,    // Core clock
  input  wire logic i_rst_n,  // Synchronous reset, active low
  input  wire logic i_halve,  // Divide by 2
  input  wire logic i_slow,   // Divide by 256
  output logic      o_tick    // Divided clock tick
);

  logic [`SYSCTL_DIV_W-1:0] cnt_q;
  logic [`SYSCTL_DIV_W-1:0] limit;
  logic [1:0]               cfg_q;
  logic                     cfg_chg;

  // --------------------------------------------------------------------------
  // Divider
  // --------------------------------------------------------------------------
  always_comb begin
    case ({i_halve, i_slow})
      2'b00:   limit = `SYSCTL_LIM_NONE;
      2'b10:   limit = `SYSCTL_LIM_HALVE;
      2'b01:   limit = `SYSCTL_LIM_SLOW;
      default: limit = `SYSCTL_LIM_BOTH;
    endcase
  end

  assign cfg_chg = ({i_halve, i_slow} != cfg_q);

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cfg_q <= 2'h0;
    end else begin
      cfg_q <= {i_halve, i_slow};
    end
  end

  // Restart on a change so no stretched period mixes two ratios
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || cfg_chg || (cnt_q == limit)) begin
      cnt_q <= `SYSCTL_DIV_ZERO;
    end else begin
      cnt_q <= cnt_q + `SYSCTL_DIV_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= !cfg_chg && (cnt_q == limit);
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [`SYSCTL_DIV_W-1:0] gap_q;
  logic                     armed_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || o_tick) begin
      gap_q <= `SYSCTL_DIV_ZERO;
    end else begin
      gap_q <= gap_q + `SYSCTL_DIV_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || cfg_chg) begin
      armed_q <= 1'b0;
    end else if (o_tick) begin
      armed_q <= 1'b1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_tick_period: assert property (
    o_tick && armed_q && !cfg_chg |-> gap_q == limit)
    else $error("divided tick period wrong");

  a_div_512: assert property (
    o_tick && armed_q && !cfg_chg && i_halve && i_slow |-> gap_q == `SYSCTL_LIM_BOTH)
    else $error("cascaded division is not 512");

  a_div_256: assert property (
    o_tick && armed_q && !cfg_chg && !i_halve && i_slow |-> gap_q == `SYSCTL_LIM_SLOW)
    else $error("slow mode division is not 256");

endmodule : sysctl_clock_divider
`default_nettype wire

// [hdl/system_clock_power_controller.sv]
// Purpose: System controller: regulator codes, clock dividers, USB pin and power flags
// Assumes: Classic Wishbone slave, 32-bit data, 16-bit registers in low bits
// Notes:   Live pin levels are sampled when a read is accepted
//
// How it works
// - System register holds halve bit, three codes
// - Halve bit divides the clock by two
// - Reset codes pick 2.6 V, 1.8 V, 1.8 V
// - Direct drive puts level bits on D+/D-
// - Overload sets flag unless protection off; a set flag disconnects buffer
// - D+ and D- live levels readable
// - Bits enable USB receiver and D+ pull-up
// - Regulator-low and power button read live
// - Bits power down drivers and analog bias
// - Load bit applies codes, off bit shuts regulator
// - Both dividers together divide by 512
// - Halving also scales the PLL input
// - Multiplier is rate field plus one
`default_nettype none
`timescale 1ns/100ps
`include "sysctl_regs.svh"

module system_clock_power_controller (
  input  wire logic        I_CORE_CLK,             // Core clock, 10 MHz
  input  wire logic        I_RESETN,               // Synchronous reset, active low
  input  wire logic        I_WB_CYC,               // Wishbone cycle
  input  wire logic        I_WB_STB,               // Wishbone strobe
  input  wire logic        I_WB_WE,                // Wishbone write enable
  input  wire logic [3:0]  I_WB_ADR,               // Wishbone byte address
  input  wire logic [3:0]  I_WB_SEL,               // Wishbone byte enables
  input  wire logic [31:0] I_WB_DAT,               // Wishbone write data
  output logic      [31:0] O_WB_DAT,               // Wishbone read data
  output logic             O_WB_ACK,               // Wishbone acknowledge
  input  wire logic        I_DPLUS_IN,             // D+ pin level
  input  wire logic        I_DMINUS_IN,            // D- pin level
  output logic             O_DPLUS_OUT,            // D+ drive level
  output logic             O_DPLUS_OE,             // D+ drive enable
  output logic             O_DMINUS_OUT,           // D- drive level
  output logic             O_DMINUS_OE,            // D- drive enable
  output logic             O_DPLUS_PULLUP_ON,      // D+ 1.5k pull-up on
  output logic             O_USB_RECEIVER_ON,      // Differential receiver on
  input  wire logic        I_REF_PIN_OVERLOAD,     // Reference pin overload sense
  output logic             O_REF_BUFFER_ON,        // Reference buffer connected
  input  wire logic        I_REGULATOR_INPUT_LOW,  // Regulator input too low
  input  wire logic        I_POWER_BUTTON,         // Power button level
  output logic             O_ANALOG_DRIVER_OFF,    // Output drivers powered down
  output logic             O_ANALOG_BIAS_OFF,      // Analog bias powered down
  output logic             O_REGULATOR_OFF,        // Regulator shut down
  output logic      [4:0]  O_ANALOG_SUPPLY_CODE,   // Applied analog/USB code
  output logic      [4:0]  O_IO_SUPPLY_CODE,       // Applied I/O code
  output logic      [4:0]  O_CORE_SUPPLY_CODE,     // Applied core code
  input  wire logic [3:0]  I_PLL_RATECTL,          // PLL rate control field
  output logic      [4:0]  O_PLL_MULT,             // PLL multiplier
  output logic             O_VCO_ON,               // Oscillator powered
  output logic             O_DIVIDED_TICK          // Clock tick to PLL and analog
);

  // --------------------------------------------------------------------------
  // Bus request
  // --------------------------------------------------------------------------
  sysctl_pkg::wb_req_t    req;
  sysctl_pkg::bus_state_t state_q;
  sysctl_pkg::sys_reg_t   sys_q;
  sysctl_pkg::sys_reg_t   applied_q;
  sysctl_pkg::flags_reg_t flags_q;
  sysctl_pkg::flags_reg_t flags_wr;
  sysctl_pkg::flags_reg_t flags_rd;
  logic                   access;
  logic                   commit_wr;
  logic                   hit_sys;
  logic                   hit_flags;
  logic                   wr_sys;
  logic                   wr_flags;
  logic                   load_rise;
  logic                   ovl_set;
  logic                   flag_d;
  logic [31:0]            rdata_d;

  assign req = {I_WB_CYC, I_WB_STB, I_WB_WE, I_WB_ADR, I_WB_SEL, I_WB_DAT};
  assign access = req.cyc && req.stb;

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [3:0]  sel);
    logic [15:0] res;
    res = old_v;
    if (sel[`SYSCTL_LANE_LO]) begin
      res[7:0] = new_v[7:0];
    end
    if (sel[`SYSCTL_LANE_HI]) begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction : merge16

  always_comb begin
    hit_sys   = 1'b0;
    hit_flags = 1'b0;
    if (req.adr[1:0] != `SYSCTL_WORD_LSB) begin
      hit_sys = 1'b0;
    end else if (req.adr == `SYSCTL_OFS_SYSTEM) begin
      hit_sys = 1'b1;
    end else if (req.adr == `SYSCTL_OFS_FLAGS) begin
      hit_flags = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------------
  // One wait state; a write lands on the edge where the master sees ack
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      state_q <= sysctl_pkg::BUS_IDLE;
    end else begin
      case (state_q)
        sysctl_pkg::BUS_IDLE: begin
          if (access) begin
            state_q <= sysctl_pkg::BUS_ACK;
          end
        end
        default: begin
          state_q <= sysctl_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      O_WB_ACK <= 1'b0;
    end else begin
      O_WB_ACK <= (state_q == sysctl_pkg::BUS_IDLE) && access;
    end
  end

  assign commit_wr = (state_q == sysctl_pkg::BUS_ACK) && access && req.we;
  assign wr_sys    = commit_wr && hit_sys;
  assign wr_flags  = commit_wr && hit_flags;
  assign flags_wr  = merge16(flags_q, req.dat[15:0], req.sel);

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always_comb begin
    flags_rd                     = flags_q;
    flags_rd.dplus_level         = I_DPLUS_IN;
    flags_rd.dminus_level        = I_DMINUS_IN;
    flags_rd.regulator_input_low = I_REGULATOR_INPUT_LOW;
    flags_rd.power_button_level  = I_POWER_BUTTON;
    rdata_d = `SYSCTL_RDATA_ZERO;
    if (hit_sys) begin
      rdata_d = {`SYSCTL_HALF_ZERO, sys_q};
    end else if (hit_flags) begin
      rdata_d = {`SYSCTL_HALF_ZERO, flags_rd};
    end
  end

  // Unmapped words answer with zero data rather than stall the bus
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      O_WB_DAT <= `SYSCTL_RDATA_ZERO;
    end else if ((state_q == sysctl_pkg::BUS_IDLE) && access && !req.we) begin
      O_WB_DAT <= rdata_d;
    end else begin
      O_WB_DAT <= `SYSCTL_RDATA_ZERO;
    end
  end

  // --------------------------------------------------------------------------
  // System register and regulator
  // --------------------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      sys_q <= {`SYSCTL_HALVE_RESET, `SYSCTL_AVDD_RESET,
                `SYSCTL_IOVDD_RESET, `SYSCTL_CVDD_RESET};
    end else if (wr_sys) begin
      sys_q <= merge16(sys_q, req.dat[15:0], req.sel);
    end
  end

  assign load_rise = wr_flags && flags_wr.regulator_load_strobe
                     && !flags_q.regulator_load_strobe;

  // Codes only reach the regulator on a load edge, so half-written values never glitch it
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      applied_q <= {`SYSCTL_HALVE_RESET, `SYSCTL_AVDD_RESET,
                    `SYSCTL_IOVDD_RESET, `SYSCTL_CVDD_RESET};
    end else if (load_rise) begin
      applied_q <= sys_q;
    end
  end

  assign O_ANALOG_SUPPLY_CODE = applied_q.analog_supply_code;
  assign O_IO_SUPPLY_CODE     = applied_q.io_supply_code;
  assign O_CORE_SUPPLY_CODE   = applied_q.core_supply_code;

  // --------------------------------------------------------------------------
  // Flags register
  // --------------------------------------------------------------------------
  assign ovl_set = I_REF_PIN_OVERLOAD && !flags_q.ref_pin_protect_off;
  // Overload set wins over a clearing write in the same cycle
  assign flag_d  = ovl_set || (flags_q.ref_pin_overload_flag
                   && !(wr_flags && !flags_wr.ref_pin_overload_flag));

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      flags_q <= `SYSCTL_FLAGS_RESET;
    end else begin
      if (wr_flags) begin
        flags_q <= flags_wr;
      end
      flags_q.ref_pin_overload_flag <= flag_d;
      flags_q.dplus_level           <= 1'b0;
      flags_q.dminus_level          <= 1'b0;
      flags_q.regulator_input_low   <= 1'b0;
      flags_q.power_button_level    <= 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      O_REF_BUFFER_ON <= 1'b1;
    end else begin
      O_REF_BUFFER_ON <= !flag_d;
    end
  end

  assign O_DPLUS_OUT         = flags_q.dplus_out_level;
  assign O_DMINUS_OUT        = flags_q.dminus_out_level;
  assign O_DPLUS_OE          = flags_q.usb_pins_direct_drive;
  assign O_DMINUS_OE         = flags_q.usb_pins_direct_drive;
  assign O_USB_RECEIVER_ON   = flags_q.usb_receiver_on;
  assign O_DPLUS_PULLUP_ON   = flags_q.dplus_pullup_on;
  assign O_ANALOG_DRIVER_OFF = flags_q.analog_driver_off;
  assign O_ANALOG_BIAS_OFF   = flags_q.analog_bias_off;
  assign O_REGULATOR_OFF     = flags_q.regulator_off;

  // --------------------------------------------------------------------------
  // Clock path
  // --------------------------------------------------------------------------
  // One tick feeds both the PLL input and the analog block
  sysctl_clock_divider u_divider (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RESETN),
    .i_halve (sys_q.clock_halve_sel),
    .i_slow  (flags_q.slow_clock_sel),
    .o_tick  (O_DIVIDED_TICK)
  );

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RESETN) begin
      O_PLL_MULT <= `SYSCTL_PLL_MULT_ONE;
      O_VCO_ON   <= 1'b0;
    end else begin
      O_PLL_MULT <= {1'b0, I_PLL_RATECTL} + `SYSCTL_PLL_MULT_ONE;
      O_VCO_ON   <= (I_PLL_RATECTL != `SYSCTL_PLL_RATE_OFF);
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESETN);

  sequence s_flags_read;
    (state_q == sysctl_pkg::BUS_IDLE) && access && !req.we && hit_flags;
  endsequence

  sequence s_flags_write_lo;
    (state_q == sysctl_pkg::BUS_IDLE) && access && req.we && hit_flags
      && req.sel[`SYSCTL_LANE_LO] ##1 O_WB_ACK && wr_flags;
  endsequence

  sequence s_flags_write_hi;
    (state_q == sysctl_pkg::BUS_IDLE) && access && req.we && hit_flags
      && req.sel[`SYSCTL_LANE_HI] ##1 O_WB_ACK && wr_flags;
  endsequence

  a_ack_single: assert property (
    O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held longer than one cycle");

  a_reset_codes: assert property (disable iff (1'b0)
    !I_RESETN |=> O_ANALOG_SUPPLY_CODE == `SYSCTL_AVDD_RESET
      && O_IO_SUPPLY_CODE == `SYSCTL_IOVDD_RESET
      && O_CORE_SUPPLY_CODE == `SYSCTL_CVDD_RESET)
    else $error("regulator codes wrong after reset");

  a_load_applies: assert property (
    load_rise |=> O_CORE_SUPPLY_CODE == $past(sys_q.core_supply_code)
      && O_ANALOG_SUPPLY_CODE == $past(sys_q.analog_supply_code))
    else $error("load pulse did not apply codes");

  a_codes_hold: assert property (
    !load_rise |=> $stable(O_IO_SUPPLY_CODE) && $stable(O_CORE_SUPPLY_CODE))
    else $error("codes changed without load pulse");

  a_pins_drive: assert property (
    s_flags_write_hi |=> O_DPLUS_OE == $past(req.dat[12], 1)
      && O_DMINUS_OUT == $past(req.dat[14], 1))
    else $error("direct drive pins not from written bits");

  a_overload_cut: assert property (
    I_REF_PIN_OVERLOAD && !flags_q.ref_pin_protect_off
      |=> flags_q.ref_pin_overload_flag && !O_REF_BUFFER_ON)
    else $error("overload did not disconnect buffer");

  a_protect_off: assert property (
    flags_q.ref_pin_protect_off && !flags_q.ref_pin_overload_flag && !wr_flags
      |=> !flags_q.ref_pin_overload_flag && O_REF_BUFFER_ON)
    else $error("protection acted while disabled");

  a_live_levels: assert property (
    s_flags_read |=> O_WB_ACK && O_WB_DAT[9] == $past(I_DPLUS_IN)
      && O_WB_DAT[8] == $past(I_DMINUS_IN)
      && O_WB_DAT[5] == $past(I_REGULATOR_INPUT_LOW)
      && O_WB_DAT[4] == $past(I_POWER_BUTTON))
    else $error("live levels wrong in read data");

  a_usb_enables: assert property (
    s_flags_write_lo |=> O_USB_RECEIVER_ON == $past(req.dat[7], 1)
      && O_DPLUS_PULLUP_ON == $past(req.dat[6], 1)
      && O_ANALOG_DRIVER_OFF == $past(req.dat[3], 1))
    else $error("receiver or pull-up not from written bits");

  a_pll_mult: assert property (
    ##1 O_PLL_MULT == {1'b0, $past(I_PLL_RATECTL)} + `SYSCTL_PLL_MULT_ONE
      && O_VCO_ON == ($past(I_PLL_RATECTL) != `SYSCTL_PLL_RATE_OFF))
    else $error("multiplier not rate field plus one");

endmodule : system_clock_power_controller
`default_nettype wire

// [pkg/sysctl_pkg.sv]
// Purpose: Types shared by the system controller files
// Assumes: Register constants come from sysctl_regs.svh
// Notes:   Field order of the structs is the register bit order, msb first
`default_nettype none
`include "sysctl_regs.svh"

package sysctl_pkg;

  // --------------------------------------------------------------------------
  // Register layouts
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       clock_halve_sel;
    logic [4:0] analog_supply_code;
    logic [4:0] io_supply_code;
    logic [4:0] core_supply_code;
  } sys_reg_t;

  typedef struct packed {
    logic slow_clock_sel;
    logic dminus_out_level;
    logic dplus_out_level;
    logic usb_pins_direct_drive;
    logic ref_pin_overload_flag;
    logic ref_pin_protect_off;
    logic dplus_level;
    logic dminus_level;
    logic usb_receiver_on;
    logic dplus_pullup_on;
    logic regulator_input_low;
    logic power_button_level;
    logic analog_driver_off;
    logic analog_bias_off;
    logic regulator_load_strobe;
    logic regulator_off;
  } flags_reg_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;

endpackage : sysctl_pkg
`default_nettype wire

// [pkg/sysctl_regs.svh]
// Purpose: Register offsets, reset values and clock constants of the system controller
// Assumes: Included by bare name from the package and design files
// Notes:   Definitions only
`ifndef SYSCTL_REGS_SVH
`define SYSCTL_REGS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define SYSCTL_ADR_W          4
`define SYSCTL_OFS_SYSTEM     4'h0
`define SYSCTL_OFS_FLAGS      4'h4
`define SYSCTL_LANE_LO        0
`define SYSCTL_LANE_HI        1
`define SYSCTL_WORD_LSB       2'h0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SYSCTL_AVDD_RESET     5'h03
`define SYSCTL_IOVDD_RESET    5'h00
`define SYSCTL_CVDD_RESET     5'h0C
`define SYSCTL_HALVE_RESET    1'h0
`define SYSCTL_FLAGS_RESET    16'h0000
`define SYSCTL_RDATA_ZERO     32'h0000_0000
`define SYSCTL_HALF_ZERO      16'h0000

// ----------------------------------------------------------------------------
// Clock division
// ----------------------------------------------------------------------------
`define SYSCTL_DIV_W          9
`define SYSCTL_DIV_ZERO       9'h000
`define SYSCTL_DIV_ONE        9'h001
`define SYSCTL_LIM_NONE       9'h000
`define SYSCTL_LIM_HALVE      9'h001
`define SYSCTL_LIM_SLOW       9'h0FF
`define SYSCTL_LIM_BOTH       9'h1FF

// ----------------------------------------------------------------------------
// Clock multiplier
// ----------------------------------------------------------------------------
`define SYSCTL_PLL_RATE_OFF   4'h0
`define SYSCTL_PLL_MULT_ONE   5'h01

`endif

// [verification/tb_system_clock_power_controller.sv]
// Purpose: Self-checking bench of the system controller
// Assumes: Wishbone ack one cycle after take
// Notes:   Random values from an LFSR seeded at 95
`timescale 1ns/100ps
`default_nettype none
module tb_system_clock_power_controller;
  logic clk = 1'b0, rst_n = 1'b0, ovl = 1'b0, low = 1'b0, pb = 1'b0, conn = 1'b0;
  logic dp, dm, ack, dpo, dpe, dmo, dme, pu, rx, buf_on, drv, bias, roff, vco, tick;
  logic [3:0]  rate = 4'h0;
  logic [4:0]  ac, ic, cc, mult;
  logic [15:0] seed = 16'h005F, cur = 16'h0C0C, w;
  logic [31:0] r, rd;
  int          bad_count = 0, checked = 0, cycles = 0, g;
  sysctl_pkg::wb_req_t rq = '0;

  system_clock_power_controller system_clock_power_controller_inst (
    .I_CORE_CLK(clk), .I_RESETN(rst_n), .I_WB_CYC(rq.cyc), .I_WB_STB(rq.stb),
    .I_WB_WE(rq.we), .I_WB_ADR(rq.adr), .I_WB_SEL(rq.sel), .I_WB_DAT(rq.dat),
    .O_WB_DAT(rd), .O_WB_ACK(ack), .I_DPLUS_IN(dp), .I_DMINUS_IN(dm),
    .O_DPLUS_OUT(dpo), .O_DPLUS_OE(dpe), .O_DMINUS_OUT(dmo), .O_DMINUS_OE(dme),
    .O_DPLUS_PULLUP_ON(pu), .O_USB_RECEIVER_ON(rx), .I_REF_PIN_OVERLOAD(ovl),
    .O_REF_BUFFER_ON(buf_on), .I_REGULATOR_INPUT_LOW(low), .I_POWER_BUTTON(pb),
    .O_ANALOG_DRIVER_OFF(drv), .O_ANALOG_BIAS_OFF(bias), .O_REGULATOR_OFF(roff),
    .O_ANALOG_SUPPLY_CODE(ac), .O_IO_SUPPLY_CODE(ic), .O_CORE_SUPPLY_CODE(cc),
    .I_PLL_RATECTL(rate), .O_PLL_MULT(mult), .O_VCO_ON(vco), .O_DIVIDED_TICK(tick));
  usb_host_model usb_host_model_inst (.i_attached(conn), .i_dp_oe(dpe), .i_dp_out(dpo),
    .i_dm_oe(dme), .i_dm_out(dmo), .i_pullup(pu), .o_dplus(dp), .o_dminus(dm));

  always #50 clk = ~clk;
  // Longest test is the divide-by-512 pass
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] div_n(input logic h, input logic s);
    return (h ? 32'h2 : 32'h1) * (s ? 32'h100 : 32'h1);
  endfunction : div_n
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // Called just after a rising edge; ack sampled pre-update
  task automatic wb(input logic we, input logic [3:0] a, input logic [15:0] d,
                    output logic [31:0] q);
    rq <= '{1'b1, 1'b1, we, a, 4'hF, {16'h0000, d}};
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    rq <= '0;
    @(posedge clk);
  endtask : wb
  task automatic gap(output int n);
    n = 0;
    while (tick !== 1'b1) @(posedge clk);
    do begin
      @(posedge clk);
      n++;
    end while (tick !== 1'b1);
  endtask : gap
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, 4'h0, 16'h0000, r);
    chk(r, 32'h0000_0C0C);
    chk(32'({ac, ic, cc}), 32'h0C0C);
    wb(1'b0, 4'h4, 16'h0000, r);
    chk(r, 32'h0000_0300);
    chk(32'({buf_on, mult, vco}), 32'h42);
    $display("done: reset values");
    // Drivers off ahead of any slow mode pick; multiplier stays 1x meanwhile
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 4'h4, 16'h0008, r);
      seed = lfsr(seed);
      wb(1'b1, 4'h0, seed, r);
      wb(1'b0, 4'h0, 16'h0000, r);
      chk(r, 32'(seed));
      chk(32'({ac, ic, cc}), 32'(cur[14:0]));
      cur = seed;
      seed = lfsr(seed);
      w = (seed & 16'hF4CD) | 16'h0002 | (seed[15] ? 16'h0008 : 16'h0000);
      wb(1'b1, 4'h4, w, r);
      chk(32'({ac, ic, cc}), 32'(cur[14:0]));
      wb(1'b0, 4'h4, 16'h0000, r);
      chk(32'(r[15:0] & 16'hF4CF), 32'(w));
      chk(32'({dmo, dpo, dpe, dme, rx, pu, drv, bias, roff}),
          32'({w[14:12], w[12], w[7:6], w[3:2], w[0]}));
    end
    wb(1'b1, 4'hC, 16'hFFFF, r);
    wb(1'b1, 4'h1, 16'hFFFF, r);
    wb(1'b0, 4'h0, 16'h0000, r);
    chk(r, 32'(cur));
    wb(1'b0, 4'h8, 16'h0000, r);
    chk(r, 32'h0);
    $display("done: registers");
    wb(1'b1, 4'h4, 16'h0000, r);
    for (int i = 0; i < 8; i++) begin
      conn <= i[0];
      pb <= i[1];
      low <= i[2];
      wb(1'b0, 4'h4, 16'h0000, r);
      chk(32'(r[9:4]), 32'({~i[0], ~i[0], 2'b00, i[2], i[1]}));
    end
    wb(1'b1, 4'h4, 16'h0040, r);
    wb(1'b0, 4'h4, 16'h0000, r);
    chk(32'(r[9:8]), 32'h2);
    wb(1'b1, 4'h4, 16'h5000, r);
    wb(1'b0, 4'h4, 16'h0000, r);
    chk(32'(r[9:8]), 32'h1);
    $display("done: usb pins");
    wb(1'b1, 4'h4, 16'h0000, r);
    for (int i = 0; i < 2; i++) begin
      ovl <= 1'b1;
      @(posedge clk);
      ovl <= 1'b0;
      wb(1'b0, 4'h4, 16'h0000, r);
      chk(32'({r[11], buf_on}), i ? 32'h1 : 32'h2);
      wb(1'b1, 4'h4, 16'h0400, r);
    end
    $display("done: overload");
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 4'h0, {i[0], cur[14:0]}, r);
      wb(1'b1, 4'h4, 16'h0008, r);
      wb(1'b1, 4'h4, {i[1], 15'h0008}, r);
      gap(g);
      gap(g);
      chk(32'(g), div_n(i[0], i[1]));
    end
    $display("done: dividers");
    // Full rate back before the multiplier runs up
    wb(1'b1, 4'h4, 16'h0000, r);
    wb(1'b1, 4'h0, {1'b0, cur[14:0]}, r);
    for (int i = 0; i < 16; i++) begin
      rate <= 4'(i);
      @(posedge clk);
      @(posedge clk);
      chk(32'({vco, mult}), 32'({i != 0, 5'(i + 1)}));
    end
    $display("done: multiplier");
    complete_run();
  end
endmodule : tb_system_clock_power_controller
`default_nettype wire

// [verification/usb_host_model.sv]
// Purpose: Host side of the D+/D- pins, cable plugged or not
// Assumes: 1M board pull-ups, 15k host pull-downs
// Notes:   Device drive wins over all resistors
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
  input  wire logic i_attached, // Cable plugged in
  input  wire logic i_dp_oe,    // Device drives D+
  input  wire logic i_dp_out,   // Device D+ level
  input  wire logic i_dm_oe,    // Device drives D-
  input  wire logic i_dm_out,   // Device D- level
  input  wire logic i_pullup,   // Device 1.5k pull-up on D+
  output logic      o_dplus,    // D+ wire level
  output logic      o_dminus    // D- wire level
);
  // Host pull-downs beat 1M, lose to 1.5k
  assign o_dplus  = i_dp_oe ? i_dp_out : (i_pullup | !i_attached);
  assign o_dminus = i_dm_oe ? i_dm_out : !i_attached;
endmodule : usb_host_model
`default_nettype wire
